// ==== design/i2c_seq_pkg.sv ====
// Package: register map, field layout, status codes and timing constants.
package i2c_seq_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [9:0]  CTRL_IDX  = 10'h0d8;
  localparam logic [9:0]  STAT_IDX  = 10'h0d9;
  localparam logic [9:0]  DATA_IDX  = 10'h0da;
  localparam logic [9:0]  OWN_IDX   = 10'h0db;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [11:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [11:0] OWN_ADDR  = {OWN_IDX, 2'b00};

  // Control register field positions.
  localparam int EN_BIT       = 6;
  localparam int START_BIT    = 5;
  localparam int STOP_BIT     = 4;
  localparam int SI_BIT       = 3;
  localparam int ACK_BIT      = 2;
  localparam int RATE_SEL_BIT = 0;

  // Reset values.
  localparam logic [7:0] OWN_RST   = 8'h00;
  localparam logic [7:0] STAT_IDLE = 8'hf8;

  // Status codes.
  localparam logic [7:0] START_DONE = 8'h08;
  localparam logic [7:0] REP_START  = 8'h10;
  localparam logic [7:0] MT_ADR_ACK = 8'h18;
  localparam logic [7:0] MT_ADR_NAK = 8'h20;
  localparam logic [7:0] MT_DAT_ACK = 8'h28;
  localparam logic [7:0] MT_DAT_NAK = 8'h30;
  localparam logic [7:0] ARB_LOST   = 8'h38;
  localparam logic [7:0] MR_ADR_ACK = 8'h40;
  localparam logic [7:0] MR_ADR_NAK = 8'h48;
  localparam logic [7:0] MR_DAT_ACK = 8'h50;
  localparam logic [7:0] MR_DAT_NAK = 8'h58;
  localparam logic [7:0] SR_SLA_W   = 8'h60;
  localparam logic [7:0] AL_SLA_W   = 8'h68;
  localparam logic [7:0] SR_GC      = 8'h70;
  localparam logic [7:0] AL_GC      = 8'h78;
  localparam logic [7:0] SR_DAT_ACK = 8'h80;
  localparam logic [7:0] SR_DAT_NAK = 8'h88;
  localparam logic [7:0] GC_DAT_ACK = 8'h90;
  localparam logic [7:0] GC_DAT_NAK = 8'h98;
  localparam logic [7:0] SR_STOP    = 8'ha0;
  localparam logic [7:0] ST_SLA_R   = 8'ha8;
  localparam logic [7:0] AL_SLA_R   = 8'hb0;
  localparam logic [7:0] ST_DAT_ACK = 8'hb8;
  localparam logic [7:0] ST_DAT_NAK = 8'hc0;
  localparam logic [7:0] ST_LAST    = 8'hc8;

  // Internal bit-rate generator: half a bus-clock period.
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;

  // APB request from the master.
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_s;

endpackage

// ==== design/i2c_mode_sequencer.sv ====
// Two-wire bus controller: master and slave byte sequencing behind APB.
//
// The APB register port was decided locally.
`timescale 1ns/1ns
// Summary of operation
// - Assert-acknowledge low: never answer own address.
// - Master address byte carries read/write direction bit.
// - Bytes shift as eight bits plus acknowledge.
// - Start request begins START once bus free.
// - After START, flag set with status 08h.
// - Address-write done reports 18h, 20h or 38h.
// - Address-read done reports 40h, 48h or 38h.
// - After repeated START, direction picks next mode.
// - Addressed slave: direction picks receive or transmit.
// - Slave transmits on SDA; START, STOP bound transfers.
// - Own or general address raises event request.
// - Master request waits until bus is free.
// - Lost arbitration falls back to slave at once.
// - After 10h, address-read switches to master receive.
// - Data states: loaded byte sent, acknowledge sampled.
// - Flag clear with start only: repeated START.
// - Flag clear with stop only: STOP, stop auto-clears.
// - Start and stop together: STOP then START.
// - Status low bits zero; F8h leaves flag clear.
// - After 38h, start request retries when bus free.

module i2c_mode_sequencer #(
  parameter int unsigned HALF_CYC = i2c_seq_pkg::SCL_HALF_CYC
) (
  input  logic                  i_core_clk,
  input  logic                  i_rst_n,
  input  i2c_seq_pkg::apb_req_s i_apb,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  input  logic                  i_scl,
  input  logic                  i_sda,
  input  logic                  i_rate_tick,
  output logic                  o_scl_out,
  output logic                  o_scl_oe_n,
  output logic                  o_sda_out,
  output logic                  o_sda_oe_n,
  output logic                  o_event_req
);
  import i2c_seq_pkg::*;

  // The divider counter is eight bits wide.
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_chk
    $error("HALF_CYC must lie between 2 and 255");
  end

  typedef enum logic [2:0] {
    M_IDLE, M_WAIT, M_START, M_RUN, M_STOP, M_RSTART
  } mst_e;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  mst_e        mst;
  logic [1:0]  stp;
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [2:0]  rtk_q;
  logic        scl_hi;
  logic        sda_hi;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        bus_busy;
  logic [7:0]  tmr;
  logic        half_tick;
  logic        en;
  logic        start_request;
  logic        stop_request;
  logic        si;
  logic        assert_acknowledge;
  logic        rate_source_select;
  logic [7:0]  own;
  logic [7:0]  shreg;
  logic [7:0]  status;
  logic [3:0]  cnt;
  logic        got_rise;
  logic        scl_rel;
  logic        sda_rel;
  logic        slv;
  logic        tx;
  logic        first;
  logic        lost;
  logic        hold;
  logic        rep;
  logic        rd;
  logic        gc;
  logic        myack;
  logic        ack_in;
  logic        ev;
  logic        stop_clr;
  logic        setup;
  logic        wr;
  logic        wr_ctrl;
  logic        dat_wr;
  logic        known;
  logic [31:0] rd_word;
  logic        adr_hit;
  logic        gc_hit;
  logic        sel_me;

  // Pins and the external rate source come from other domains.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      rtk_q <= 3'h0;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
      rtk_q <= {rtk_q[1:0], i_rate_tick};
    end
  end

  // Edges and bus conditions, seen only past the second stage.
  assign scl_hi    = scl_q[1];
  assign sda_hi    = sda_q[1];
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // Bus-free tracking; a master request waits on it.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !en) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      bus_busy <= 1'b0;
    end
  end

  // Half-period tick, from the divider or the external source.
  assign half_tick = rate_source_select ? (rtk_q[1] & ~rtk_q[2])
                                        : (tmr == HALF_LAST);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || half_tick) begin
      tmr <= 8'h00;
    end else begin
      tmr <= tmr + 8'h01;
    end
  end

  // Address comparison against own and general-call addresses.
  assign adr_hit = shreg[7:1] == own[7:1];
  assign gc_hit  = own[0] && shreg[7:1] == 7'h00;
  assign sel_me  = assert_acknowledge & (adr_hit | gc_hit);

  // APB decode; the slave answers without wait states.
  assign setup   = i_apb.psel & ~i_apb.penable;
  assign wr      = i_apb.psel & i_apb.penable & o_pready
                 & i_apb.pwrite;
  assign wr_ctrl = wr && i_apb.paddr == CTRL_ADDR;
  assign dat_wr  = wr && i_apb.paddr == DATA_ADDR;

  // Read mux; unmapped addresses read zero and raise an error.
  always_comb begin
    rd_word = 32'h0000_0000;
    known   = 1'b1;
    case (i_apb.paddr)
      CTRL_ADDR: rd_word[7:0] = {1'b0, en, start_request,
                                 stop_request, si, assert_acknowledge,
                                 1'b0, rate_source_select};
      STAT_ADDR: rd_word[7:0] = {status[7:3], 3'b000};
      DATA_ADDR: rd_word[7:0] = shreg;
      OWN_ADDR:  rd_word[7:0] = own;
      default:   known = 1'b0;
    endcase
  end

  // Answer registers are loaded in the setup cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~known;
      if (setup) begin
        o_prdata <= rd_word;
      end
    end
  end

  // Software control bits; the stop request also clears itself.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      en                 <= 1'b0;
      start_request      <= 1'b0;
      stop_request       <= 1'b0;
      assert_acknowledge <= 1'b0;
      rate_source_select <= 1'b0;
      own                <= OWN_RST;
    end else begin
      if (wr_ctrl) begin
        en                 <= i_apb.pwdata[EN_BIT];
        start_request      <= i_apb.pwdata[START_BIT];
        stop_request       <= i_apb.pwdata[STOP_BIT];
        assert_acknowledge <= i_apb.pwdata[ACK_BIT];
        rate_source_select <= i_apb.pwdata[RATE_SEL_BIT];
      end
      if (stop_clr) begin
        stop_request <= 1'b0;
      end
      if (wr && i_apb.paddr == OWN_ADDR) begin
        own <= i_apb.pwdata[7:0];
      end
    end
  end

  // Event flag: writing zero clears it, a new event wins the race.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      si <= 1'b0;
    end else if (ev) begin
      si <= 1'b1;
    end else if (wr_ctrl && !i_apb.pwdata[SI_BIT]) begin
      si <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low.
  always_ff @(posedge i_core_clk) begin
    o_scl_out <= 1'b0;
    o_sda_out <= 1'b0;
  end

  assign o_scl_oe_n  = scl_rel;
  assign o_sda_oe_n  = sda_rel;
  assign o_event_req = si;

  // Protocol engine: master sequencing, bit shifting, status codes.
  // Later assignments in this process take priority.
  always_ff @(posedge i_core_clk) begin
    ev       <= 1'b0;
    stop_clr <= 1'b0;
    if (!i_rst_n || !en) begin
      mst      <= M_IDLE;
      stp      <= 2'd0;
      scl_rel  <= 1'b1;
      sda_rel  <= 1'b1;
      slv      <= 1'b0;
      tx       <= 1'b0;
      first    <= 1'b0;
      lost     <= 1'b0;
      hold     <= 1'b0;
      rep      <= 1'b0;
      rd       <= 1'b0;
      gc       <= 1'b0;
      myack    <= 1'b0;
      ack_in   <= 1'b0;
      cnt      <= 4'd0;
      got_rise <= 1'b0;
      status   <= STAT_IDLE;
      if (!i_rst_n) begin
        shreg <= 8'h00;
      end
    end else begin
      // Master line sequencing, one step per half period.
      if (half_tick) begin
        unique case (mst)
          M_IDLE: begin
            if (start_request && !slv && !hold) begin
              mst <= M_WAIT;
              rep <= 1'b0;
            end
          end
          M_WAIT: begin
            if (!bus_busy && scl_hi && sda_hi) begin
              sda_rel <= 1'b0;
              mst     <= M_START;
            end
          end
          M_START: begin
            scl_rel  <= 1'b0;
            mst      <= M_RUN;
            first    <= 1'b1;
            tx       <= 1'b1;
            cnt      <= 4'd0;
            got_rise <= 1'b0;
            hold     <= 1'b1;
            ev       <= 1'b1;
            status   <= rep ? REP_START : START_DONE;
          end
          M_RUN: begin
            // Released clock goes low only once seen high.
            if (!hold) begin
              if (!scl_rel) begin
                scl_rel <= 1'b1;
              end else if (scl_hi) begin
                scl_rel <= 1'b0;
              end
            end
          end
          M_STOP: begin
            stp <= stp + 2'd1;
            if (stp == 2'd0) begin
              sda_rel <= 1'b0;
            end else if (stp == 2'd1) begin
              scl_rel <= 1'b1;
            end else begin
              stp <= 2'd2;
              if (scl_hi) begin
                sda_rel  <= 1'b1;
                stop_clr <= 1'b1;
                stp      <= 2'd0;
                rep      <= 1'b0;
                mst      <= start_request ? M_WAIT : M_IDLE;
              end
            end
          end
          M_RSTART: begin
            stp <= stp + 2'd1;
            if (stp == 2'd0) begin
              sda_rel <= 1'b1;
            end else if (stp == 2'd1) begin
              scl_rel <= 1'b1;
            end else begin
              stp <= 2'd2;
              if (scl_hi) begin
                sda_rel <= 1'b0;
                rep     <= 1'b1;
                stp     <= 2'd0;
                mst     <= M_START;
              end
            end
          end
        endcase
      end

      // Bit engine, shared by master and slave roles.
      if ((mst == M_RUN || mst == M_IDLE) && bus_busy) begin
        if (scl_rise) begin
          got_rise <= 1'b1;
          if (cnt == 4'd8) begin
            ack_in <= ~sda_hi;
          end else begin
            shreg <= {shreg[6:0], sda_hi};
            if (mst == M_RUN && tx && sda_rel && !sda_hi) begin
              mst     <= M_IDLE;
              scl_rel <= 1'b1;
              tx      <= 1'b0;
              lost    <= 1'b1;
            end
          end
        end
        if (scl_fall && got_rise) begin
          got_rise <= 1'b0;
          if (cnt != 4'd8) begin
            cnt <= cnt + 4'd1;
            if (cnt != 4'd7) begin
              sda_rel <= tx ? shreg[7] : 1'b1;
            end else if (tx) begin
              sda_rel <= 1'b1;
            end else if (mst == M_RUN || slv) begin
              sda_rel <= ~assert_acknowledge;
              myack   <= assert_acknowledge;
            end else if (first) begin
              sda_rel <= ~sel_me;
              myack   <= sel_me;
              gc      <= gc_hit & ~adr_hit;
            end else begin
              sda_rel <= 1'b1;
            end
          end else begin
            // Byte and acknowledge complete.
            cnt     <= 4'd0;
            first   <= 1'b0;
            sda_rel <= 1'b1;
            if (mst == M_RUN) begin
              hold <= 1'b1;
              ev   <= 1'b1;
              if (first) begin
                tx     <= ~rd;
                status <= rd ? (ack_in ? MR_ADR_ACK : MR_ADR_NAK)
                             : (ack_in ? MT_ADR_ACK : MT_ADR_NAK);
              end else if (tx) begin
                status <= ack_in ? MT_DAT_ACK : MT_DAT_NAK;
              end else begin
                status <= myack ? MR_DAT_ACK : MR_DAT_NAK;
              end
            end else if (first && myack) begin
              slv     <= 1'b1;
              tx      <= shreg[0];
              hold    <= 1'b1;
              ev      <= 1'b1;
              scl_rel <= 1'b0;
              lost    <= 1'b0;
              if (lost) begin
                status <= gc ? AL_GC
                        : (shreg[0] ? AL_SLA_R : AL_SLA_W);
              end else begin
                status <= gc ? SR_GC
                        : (shreg[0] ? ST_SLA_R : SR_SLA_W);
              end
            end else if (slv) begin
              hold    <= 1'b1;
              ev      <= 1'b1;
              scl_rel <= 1'b0;
              if (tx) begin
                tx     <= ack_in;
                status <= !ack_in ? ST_DAT_NAK
                        : (assert_acknowledge ? ST_DAT_ACK : ST_LAST);
              end else if (gc) begin
                status <= myack ? GC_DAT_ACK : GC_DAT_NAK;
              end else begin
                status <= myack ? SR_DAT_ACK : SR_DAT_NAK;
              end
            end else if (lost) begin
              hold   <= 1'b1;
              ev     <= 1'b1;
              status <= ARB_LOST;
            end
          end
        end
      end

      // START and STOP end any slave transfer in progress.
      if (start_det || stop_det) begin
        cnt      <= 4'd0;
        got_rise <= 1'b0;
        first    <= start_det;
        if (slv) begin
          slv     <= 1'b0;
          tx      <= 1'b0;
          sda_rel <= 1'b1;
          scl_rel <= 1'b1;
          hold    <= 1'b1;
          ev      <= 1'b1;
          status  <= SR_STOP;
        end
      end

      // Software has cleared the flag: carry out its request.
      // Waiting on ev too keeps the flag from being missed.
      if (hold && !si && !ev) begin
        hold   <= 1'b0;
        status <= STAT_IDLE;
        if (mst == M_RUN) begin
          if (first) begin
            rd      <= shreg[0];
            sda_rel <= shreg[7];
          end else if (stop_request) begin
            mst <= M_STOP;
            stp <= 2'd0;
          end else if (start_request) begin
            mst <= M_RSTART;
            stp <= 2'd0;
          end else begin
            sda_rel <= tx ? shreg[7] : 1'b1;
          end
        end else if (slv) begin
          scl_rel <= 1'b1;
          sda_rel <= tx ? shreg[7] : 1'b1;
        end else if (lost) begin
          lost <= 1'b0;
          if (start_request) begin
            mst <= M_WAIT;
            rep <= 1'b0;
          end
        end
      end

      if (dat_wr) begin
        shreg <= i_apb.pwdata[7:0];
      end
    end
  end

endmodule // i2c_mode_sequencer

// ==== bench/i2c_seq_assertions.sv ====
// Port-level checks bound to the two-wire mode sequencer.
`timescale 1ns/1ns
module i2c_seq_assertions #(
  parameter int unsigned HALF_CYC = 100
) (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_n,
  input wire i2c_seq_pkg::apb_req_s i_apb,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic                  i_scl,
  input wire logic                  i_sda,
  input wire logic                  i_rate_tick,
  input wire logic                  o_scl_out,
  input wire logic                  o_scl_oe_n,
  input wire logic                  o_sda_out,
  input wire logic                  o_sda_oe_n,
  input wire logic                  o_event_req
);
  import i2c_seq_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic setup;
  logic mapped;
  // Decode the setup phase once; unmapped places must answer with an error.
  assign setup = i_apb.psel && !i_apb.penable;
  assign mapped = i_apb.paddr == CTRL_ADDR || i_apb.paddr == STAT_ADDR ||
                  i_apb.paddr == DATA_ADDR || i_apb.paddr == OWN_ADDR;

  AST_READY_NEXT: assert property (setup |=> o_pready)
    else $error("ready missing after setup");
  AST_READY_ONCE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (setup && !mapped |=>
    o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_UPPER_ZERO: assert property (setup && !i_apb.pwrite |=>
    o_prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_STAT_LOW: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == STAT_ADDR |=>
    o_prdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  AST_RESET_IDLE: assert property ($rose(i_rst_n) |->
    o_scl_oe_n && o_sda_oe_n && !o_event_req && !o_pready)
    else $error("outputs not idle after reset");
  AST_OPEN_DRAIN: assert property (
    o_scl_out == 1'b0 && o_sda_out == 1'b0)
    else $error("line driven high");
  AST_FLAG_STALL: assert property (
    o_event_req && !o_scl_oe_n |=> !o_event_req || !o_scl_oe_n)
    else $error("clock released while flag set");
  AST_DISABLE_RELEASE: assert property (
    i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite &&
    i_apb.paddr == CTRL_ADDR && !i_apb.pwdata[EN_BIT] |->
    ##[1:4] (o_scl_oe_n && o_sda_oe_n) [*2])
    else $error("lines held after disable");
endmodule // i2c_seq_assertions

bind i2c_mode_sequencer i2c_seq_assertions #(.HALF_CYC(HALF_CYC)) i_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_scl(i_scl), .i_sda(i_sda), .i_rate_tick(i_rate_tick),
  .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n), .o_event_req(o_event_req));

// ==== bench/i2c_bus_partner.sv ====
// Behavioural bus target that acknowledges one write address.
`timescale 1ns/1ns
module i2c_bus_partner #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_rel,
  output logic [7:0]      o_rx_byte,
  output int              o_rx_cnt
);
  logic [7:0] sh = 8'h00;
  int         nb = 0;
  logic       first = 1'b0;
  logic       sel = 1'b0;
  initial o_sda_rel = 1'b1;
  // A START opens a frame; a STOP ends any selection.
  always @(negedge i_sda) if (i_scl) begin
    nb = 0;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) begin
    first = 1'b0;
    sel = 1'b0;
  end
  // Bits are taken on the rising clock, most significant first.
  always @(posedge i_scl) begin
    if (nb < 8) sh = {sh[6:0], i_sda};
    nb++;
  end
  // Only the acknowledge slot is driven, so the pull-up shows otherwise.
  always @(negedge i_scl) begin
    if (nb == 8) begin
      if (first) sel = (sh[7:1] == ADDR) && !sh[0];
      if (first || sel) begin
        o_rx_byte = sh;
        o_rx_cnt++;
      end
      o_sda_rel = !sel;
      first = 1'b0;
    end else if (nb == 9) begin
      o_sda_rel = 1'b1;
      nb = 0;
    end
  end
endmodule // i2c_bus_partner

// ==== bench/test_i2c_mode_sequencer.sv ====
// Self-checking bench for the two-wire mode sequencer.
`timescale 1ns/1ns
module test_i2c_mode_sequencer;
  import i2c_seq_pkg::*;
  localparam int Q = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic        m_scl = 1'b1;
  logic        m_sda = 1'b1;
  apb_req_s    apb = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        ev;
  logic        p_sda;
  logic [7:0]  p_byte;
  int          p_cnt;
  wire logic   scl = scl_oe_n & m_scl;
  wire logic   sda = sda_oe_n & m_sda & p_sda;
  logic [32:0] exp_q[$];
  logic [7:0]  exp_b[$];
  logic [31:0] rs = 32'h0000_8159;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  sb[4] = '{8'h6a, 8'h6b, 8'h00, 8'h6a};
  logic [7:0]  ss[4] = '{SR_SLA_W, ST_SLA_R, SR_GC, STAT_IDLE};

  // The rate source runs free at one eighth of the core clock, toggling on its falling edges.
  always #25 clk = ~clk;
  always #200 tick = ~tick;

  i2c_mode_sequencer #(.HALF_CYC(4)) i_i2c_mode_sequencer (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_apb(apb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda),
    .i_rate_tick(tick), .o_scl_out(), .o_scl_oe_n(scl_oe_n),
    .o_sda_out(), .o_sda_oe_n(sda_oe_n), .o_event_req(ev));

  i2c_bus_partner #(.ADDR(7'h2a)) i_i2c_bus_partner (
    .i_scl(scl), .i_sda(sda), .o_sda_rel(p_sda), .o_rx_byte(p_byte),
    .o_rx_cnt(p_cnt));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The request stands unchanged until ready is seen at a rising edge.
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [7:0] d);
    apb <= '{paddr: a, pwrite: w, pwdata: {24'h00_0000, d}, psel: 1'b1,
             penable: 1'b0};
    @(posedge clk);
    apb.penable <= 1'b1;
    // Only the bench timeout may end this wait.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic err = 1'b0);
    exp_q.push_back({err, 24'h00_0000, e});
    xfer(a, 1'b0, 8'h00);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic wait_ev();
    int n;
    n = 0;
    while (ev !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(ev, 1'b1);
  endtask

  // Bench master: START, eight bits and the acknowledge slot.
  task automatic mbyte(input logic [7:0] b, input logic ack);
    logic s;
    exp_b.push_back(b);
    m_sda <= 1'b0;
    repeat (Q) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      m_scl <= 1'b0;
      repeat (Q) @(posedge clk);
      m_sda <= (i < 8) ? b[7 - i] : 1'b1;
      repeat (Q) @(posedge clk);
      m_scl <= 1'b1;
      repeat (Q) @(posedge clk);
      s = sda;
    end
    m_scl <= 1'b0;
    chk(!s, ack);
  endtask

  task automatic mstop();
    repeat (Q) @(posedge clk);
    m_sda <= 1'b0;
    repeat (Q) @(posedge clk);
    m_scl <= 1'b1;
    repeat (Q) @(posedge clk);
    m_sda <= 1'b1;
    repeat (Q) @(posedge clk);
  endtask

  // Completed reads are compared against the oldest expectation.
  always @(posedge clk)
    if (apb.psel && apb.penable && pready && !apb.pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  // Every byte the partner takes must be the one software loaded or the bench master sent.
  always @(p_cnt) chk(p_byte, exp_b.pop_front());

  // A hang is cut short long after the tests should have finished.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      close_out();
    end
  end

  // Main sequence: registers, master traffic, then slave addressing.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, 8'h00);
    rd(STAT_ADDR, STAT_IDLE);
    rd(OWN_ADDR, OWN_RST);
    rd(DATA_ADDR, 8'h00);
    wr(STAT_ADDR, 8'h55);
    rd(STAT_ADDR, STAT_IDLE);
    rd(12'h370, 8'h00, 1'b1);
    $display("register test done");
    wr(CTRL_ADDR, 8'h61);
    wait_ev();
    rd(STAT_ADDR, START_DONE);
    wr(DATA_ADDR, 8'h54);
    exp_b.push_back(8'h54);
    wr(CTRL_ADDR, 8'h41);
    wait_ev();
    rd(STAT_ADDR, MT_ADR_ACK);
    for (int k = 0; k < 2; k++) begin
      rs = nxt(rs);
      wr(DATA_ADDR, rs[7:0]);
      exp_b.push_back(rs[7:0]);
      wr(CTRL_ADDR, 8'h41);
      wait_ev();
      rd(STAT_ADDR, MT_DAT_ACK);
    end
    wr(CTRL_ADDR, 8'h60);
    wait_ev();
    rd(STAT_ADDR, REP_START);
    wr(DATA_ADDR, 8'h56);
    exp_b.push_back(8'h56);
    wr(CTRL_ADDR, 8'h40);
    wait_ev();
    rd(STAT_ADDR, MT_ADR_NAK);
    wr(CTRL_ADDR, 8'h70);
    wait_ev();
    rd(STAT_ADDR, START_DONE);
    rd(CTRL_ADDR, 8'h68);
    wr(DATA_ADDR, 8'h57);
    exp_b.push_back(8'h57);
    wr(CTRL_ADDR, 8'h40);
    wait_ev();
    rd(STAT_ADDR, MR_ADR_NAK);
    wr(CTRL_ADDR, 8'h50);
    repeat (100) @(posedge clk);
    rd(CTRL_ADDR, 8'h40);
    rd(STAT_ADDR, STAT_IDLE);
    $display("master test done");
    wr(OWN_ADDR, 8'h6b);
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_ADDR, (k < 3) ? 8'h44 : 8'h40);
      mbyte(sb[k], k < 3);
      if (k < 3) begin
        wait_ev();
      end else begin
        repeat (40) @(posedge clk);
        chk(ev, 1'b0);
      end
      rd(STAT_ADDR, ss[k]);
      wr(CTRL_ADDR, 8'h00);
      mstop();
    end
    $display("slave test done");
    close_out();
  end
endmodule // test_i2c_mode_sequencer
